// ===== verilog/fow_pkg.sv
package fow_pkg;

    // core clock and documented access times in ns, then the wait-state floors in cycles
    localparam int CORE_CLOCK_PERIOD_NS = 10;
    localparam int PAGED_READ_TIME_NS   = 40;
    localparam int RANDOM_READ_TIME_NS  = 40;
    localparam int OTP_READ_TIME_NS     = 60;
    localparam int RANDOM_WS_FLOOR      = 1;
    localparam int OTP_WS_FLOOR         = 1;

    // wait states = ceil(t_access / t_clock - 1)
    localparam int PAGE_WS_RAW = (PAGED_READ_TIME_NS + CORE_CLOCK_PERIOD_NS - 1) / CORE_CLOCK_PERIOD_NS - 1;
    localparam int RAND_WS_RAW = (RANDOM_READ_TIME_NS + CORE_CLOCK_PERIOD_NS - 1) / CORE_CLOCK_PERIOD_NS - 1;
    localparam int OTP_WS_RAW  = (OTP_READ_TIME_NS + CORE_CLOCK_PERIOD_NS - 1) / CORE_CLOCK_PERIOD_NS - 1;

    localparam int PAGE_WS = (PAGE_WS_RAW < 0) ? 0 : PAGE_WS_RAW;
    localparam int RAND_WS = (RAND_WS_RAW < RANDOM_WS_FLOOR) ? RANDOM_WS_FLOOR : RAND_WS_RAW;
    localparam int OTP_WS  = (OTP_WS_RAW < OTP_WS_FLOOR) ? OTP_WS_FLOOR : OTP_WS_RAW;

    localparam int WS_W = 4;

    // guaranteed erase/program endurance of the flash array
    localparam int WEAR_LIMIT = 20000;
    localparam int WEAR_W     = 15;

    // bus and page geometry
    localparam int ADDR_W      = 22;
    localparam int DATA_W      = 16;
    localparam int PAGE_LSB_W  = 3;

    typedef enum logic [1:0] {
        FOW_KIND_PAGE,
        FOW_KIND_RANDOM,
        FOW_KIND_OTP
    } fow_kind_t;

endpackage : fow_pkg

// ===== verilog/fow_wait_cnt.sv
`timescale 1ns/100ps

// loadable down-counter that marks the last wait cycle
module fow_wait_cnt #(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         run,
    // status
    output logic              at_zero
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    assign at_zero = (cnt_q == '0);

    // holds at zero so a late run pulse cannot wrap the count
    assign cnt_d = load ? load_val :
                   (run && !at_zero) ? cnt_q - W'(1) : cnt_q;

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

endmodule : fow_wait_cnt

// ===== verilog/fow_ctrl.sv
// How it works
// - paged read waits ceil(40ns/period - 1)
// - random read waits ceil(40ns/period-1), minimum one
// - OTP read waits ceil(60ns/period-1), minimum one
// - flag endurance limit at 20000 erase/program cycles
`timescale 1ns/100ps

module fow_ctrl #(
    parameter int ADDR_W     = fow_pkg::ADDR_W,
    parameter int DATA_W     = fow_pkg::DATA_W,
    parameter int PAGE_LSB_W = fow_pkg::PAGE_LSB_W,
    parameter int WEAR_LIMIT = fow_pkg::WEAR_LIMIT
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    // cpu read request
    input  wire logic              rd_req,
    input  wire logic              rd_otp,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic                   rd_ready_q,
    output logic                   rd_ack_q,
    output logic [DATA_W-1:0]      rd_data_q,
    output logic                   rd_paged_q,
    // array side
    output logic                   arr_en_q,
    output logic                   arr_otp_q,
    output logic [ADDR_W-1:0]      arr_addr_q,
    input  wire logic [DATA_W-1:0] arr_rdata,
    // wear tracking
    input  wire logic              cycle_done,
    output logic                   wear_limit_q
);

    localparam int WS_W   = fow_pkg::WS_W;
    localparam int PG_DLY = fow_pkg::PAGE_WS + 1;
    localparam int RN_DLY = fow_pkg::RAND_WS + 1;
    localparam int OT_DLY = fow_pkg::OTP_WS + 1;
    // ack can still stand on the take edge of a back-to-back read, so windows open one edge later
    localparam int PG_GAP = PG_DLY - 1;
    localparam int RN_LAT = RN_DLY + 1;
    localparam int OT_GAP = OT_DLY - 1;

    typedef enum logic [0:0] {
        FOW_IDLE,
        FOW_WAIT
    } fow_state_t;

    fow_state_t                       state_q;
    fow_state_t                       state_d;
    logic [ADDR_W-PAGE_LSB_W-1:0]     page_q;
    logic                             page_valid_q;
    logic [fow_pkg::WEAR_W-1:0]       wear_q;

    wire take      = rd_req && rd_ready_q;
    wire same_page = page_valid_q && (rd_addr[ADDR_W-1:PAGE_LSB_W] == page_q);
    wire wait_zero;
    wire finish    = (state_q == FOW_WAIT) && wait_zero;

    wire fow_pkg::fow_kind_t kind_sel = rd_otp    ? fow_pkg::FOW_KIND_OTP :
                                        same_page ? fow_pkg::FOW_KIND_PAGE :
                                                    fow_pkg::FOW_KIND_RANDOM;

    wire [WS_W-1:0] ws_sel = (kind_sel == fow_pkg::FOW_KIND_OTP)  ? WS_W'(fow_pkg::OTP_WS) :
                             (kind_sel == fow_pkg::FOW_KIND_PAGE) ? WS_W'(fow_pkg::PAGE_WS) :
                                                                    WS_W'(fow_pkg::RAND_WS);

    wire wear_hit = (wear_q == fow_pkg::WEAR_W'(WEAR_LIMIT - 1));

    // count of wait cycles still owed to the array
    fow_wait_cnt #(
        .W (WS_W)
    ) u_wait (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .load     (take),
        .load_val (ws_sel),
        .run      (state_q == FOW_WAIT),
        .at_zero  (wait_zero)
    );

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            FOW_IDLE: if (take) state_d = FOW_WAIT;
            FOW_WAIT: if (wait_zero) state_d = FOW_IDLE;
            default:  state_d = FOW_IDLE;
        endcase
    end

    // bus stays held off from take until the wait count runs out
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q    <= FOW_IDLE;
            rd_ready_q <= 1'b1;
            rd_ack_q   <= 1'b0;
            arr_en_q   <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            rd_ready_q <= take ? 1'b0 : (finish ? 1'b1 : rd_ready_q);
            rd_ack_q   <= finish;
            arr_en_q   <= take ? 1'b1 : (finish ? 1'b0 : arr_en_q);
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            arr_addr_q <= '0;
            arr_otp_q  <= 1'b0;
            rd_paged_q <= 1'b0;
            rd_data_q  <= '0;
        end
        else
        begin
            if (take)
            begin
                arr_addr_q <= rd_addr;
                arr_otp_q  <= rd_otp;
                rd_paged_q <= (kind_sel == fow_pkg::FOW_KIND_PAGE);
            end
            if (finish)
                rd_data_q <= arr_rdata;
        end
    end

    // only flash reads open a page; an otp read leaves the page alone
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            page_q       <= '0;
            page_valid_q <= 1'b0;
        end
        else if (take && !rd_otp)
        begin
            page_q       <= rd_addr[ADDR_W-1:PAGE_LSB_W];
            page_valid_q <= 1'b1;
        end
    end

    // saturating tally of completed erase/program cycles
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wear_q       <= '0;
            wear_limit_q <= 1'b0;
        end
        else if (cycle_done && !wear_limit_q)
        begin
            wear_q       <= wear_q + fow_pkg::WEAR_W'(1);
            wear_limit_q <= wear_hit;
        end
    end

    chk_page_wait: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        take && kind_sel == fow_pkg::FOW_KIND_PAGE |=> (!rd_ack_q throughout (1'b1 ##PG_GAP 1'b1)) ##1 rd_ack_q)
        else $error("paged read ack at wrong cycle");

    chk_random_wait: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        take && kind_sel == fow_pkg::FOW_KIND_RANDOM |-> ##RN_LAT rd_ack_q && !$past(rd_ack_q))
        else $error("random read ack at wrong cycle");

    chk_otp_wait: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        take && rd_otp |=> (!rd_ack_q throughout (1'b1 ##OT_GAP 1'b1)) ##1 rd_ack_q)
        else $error("otp read ack at wrong cycle");

    chk_random_floor: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        take && kind_sel != fow_pkg::FOW_KIND_PAGE |-> ws_sel >= WS_W'(1))
        else $error("random or otp wait below one");

    chk_hold_off: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        take |=> !rd_ready_q && arr_en_q && arr_addr_q == $past(rd_addr))
        else $error("bus not held off during array read");

    chk_wear_flag: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(wear_limit_q) |-> wear_q == fow_pkg::WEAR_W'(WEAR_LIMIT))
        else $error("wear flag not at endurance limit");

    // only reset may drop the flag; later pulses must not wrap the tally
    chk_wear_sticky: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        wear_limit_q |=> wear_limit_q)
        else $error("wear flag dropped without reset");

    chk_ack_single: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        rd_ack_q |=> !rd_ack_q)
        else $error("read ack longer than one cycle");

    chk_ack_release: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        rd_ack_q |-> rd_ready_q && !arr_en_q)
        else $error("bus or array still held at ack");

    chk_data_capture: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        rd_ack_q |-> rd_data_q == $past(arr_rdata))
        else $error("read data not taken on ack edge");

    chk_otp_unpaged: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        take && rd_otp |=> !rd_paged_q)
        else $error("otp read marked as paged");

    cov_page_read: cover property (@(posedge ref_clk) disable iff (sys_rst)
        take && kind_sel == fow_pkg::FOW_KIND_PAGE);
    cov_otp_read: cover property (@(posedge ref_clk) disable iff (sys_rst)
        take && rd_otp);
    cov_back_to_back: cover property (@(posedge ref_clk) disable iff (sys_rst)
        rd_ack_q && take);
    cov_wear_limit: cover property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(wear_limit_q));
    cov_random_read: cover property (@(posedge ref_clk) disable iff (sys_rst)
        take && kind_sel == fow_pkg::FOW_KIND_RANDOM);

endmodule : fow_ctrl

// ===== tb/fow_array_model.sv
`timescale 1ns/100ps

module fow_array_model (
    // clock
    input  wire logic        ref_clk,
    // array side
    input  wire logic        arr_en_q,
    input  wire logic        arr_otp_q,
    input  wire logic [21:0] arr_addr_q,
    output logic      [15:0] arr_rdata
);
    int          age;
    logic [15:0] word;
    logic        ok;

    assign word = arr_addr_q[15:0] ^ {arr_addr_q[21:16], 9'h0A5, arr_otp_q};
    // word settles only once the full access time has run since enable
    assign ok = arr_en_q && (age + 1) * fow_pkg::CORE_CLOCK_PERIOD_NS >= (arr_otp_q ? 60 : 40);
    assign arr_rdata = ok ? word : ~word ^ 16'(age);

    always @(posedge ref_clk)
        age <= arr_en_q ? age + 1 : 0;
endmodule : fow_array_model

// ===== tb/fow_ctrl_tb.sv
`timescale 1ns/100ps

module fow_ctrl_tb;
    localparam int P = fow_pkg::CORE_CLOCK_PERIOD_NS;
    logic        ref_clk, sys_rst, rd_req, rd_otp, cycle_done;
    logic [21:0] rd_addr, arr_addr_q, a;
    logic [15:0] rd_data_q, arr_rdata;
    logic        rd_ready_q, rd_ack_q, rd_paged_q, arr_en_q, arr_otp_q, wear_limit_q, pg_ok;
    logic [18:0] last_pg;
    logic [31:0] seed = 32'h303E;
    logic [31:0] r;
    int          failures, samples_checked, cycles, wcnt;

    fow_ctrl #(.WEAR_LIMIT(5)) u_fow_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst), .rd_req(rd_req),
        .rd_otp(rd_otp), .rd_addr(rd_addr), .rd_ready_q(rd_ready_q), .rd_ack_q(rd_ack_q),
        .rd_data_q(rd_data_q), .rd_paged_q(rd_paged_q), .arr_en_q(arr_en_q), .arr_otp_q(arr_otp_q),
        .arr_addr_q(arr_addr_q), .arr_rdata(arr_rdata), .cycle_done(cycle_done),
        .wear_limit_q(wear_limit_q));
    fow_array_model u_fow_array_model (.ref_clk(ref_clk), .arr_en_q(arr_en_q), .arr_otp_q(arr_otp_q),
        .arr_addr_q(arr_addr_q), .arr_rdata(arr_rdata));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic int ws(input int t, input int fl);
        int w;
        w = (t + P - 1) / P - 1;
        return (w < fl) ? fl : w;
    endfunction : ws

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    // called just after an edge; returns just after the ack edge so reads run back to back
    task automatic rd(input logic otp, input logic [21:0] ad);
        int   n;
        logic pg;
        pg = !otp && pg_ok && ad[21:3] == last_pg;
        rd_req = 1'b1;
        rd_otp = otp;
        rd_addr = ad;
        @(posedge ref_clk);
        #1;
        if (!otp)
        begin
            pg_ok = 1'b1;
            last_pg = ad[21:3];
        end
        // a request held while busy must be ignored
        rd_req = rnd() % 2 == 1;
        rd_addr = ~ad;
        rd_otp = ~otp;
        n = 0;
        while (rd_ack_q !== 1'b1 && n < 20)
        begin
            // each pulse is a whole sector erase then its program
            cycle_done = rnd() % 4 == 0;
            @(posedge ref_clk);
            #1;
            n++;
        end
        cycle_done = 1'b0;
        check(n, otp ? ws(60, 1) + 1 : pg ? ws(40, 0) + 1 : ws(40, 1) + 1);
        check(rd_data_q, ad[15:0] ^ {ad[21:16], 9'h0A5, otp});
        check(rd_paged_q, pg);
    endtask : rd

    initial
    begin
        ref_clk = 1'b0;
        forever #(P / 2) ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycle_done === 1'b1)
            wcnt++;
        if (cycles == 20000)
        begin
            failures++;
            stop_test();
        end
    end

    initial
    begin
        {rd_req, rd_otp, rd_addr, cycle_done} = '0;
        a = '0;
        repeat (2)
        begin
            sys_rst = 1'b1;
            pg_ok = 1'b0;
            repeat (6) @(posedge ref_clk);
            #1;
            wcnt = 0;
            sys_rst = 1'b0;
            check({rd_ready_q, rd_ack_q, arr_en_q, wear_limit_q, rd_paged_q, rd_data_q}, 21'h100000);
            repeat (30)
            begin
                r = rnd();
                a = r[2] ? {a[21:3], r[6:4]} : r[31:10];
                if (wcnt < 5)
                    check(wear_limit_q, 1'b0);
                // the otp array is only ever read here, never programmed
                rd(r[1:0] == 2'h0, a);
            end
            rd_req = 1'b0;
            repeat (2) @(posedge ref_clk);
            #1;
            check(wear_limit_q, wcnt >= 5);
        end
        stop_test();
    end
endmodule : fow_ctrl_tb
